// file: inc/sfpes_defines.svh
`ifndef SFPES_DEFINES_SVH
`define SFPES_DEFINES_SVH

// ====================================================================
// Clock rate
`define REF_CLK_MHZ 200

// ====================================================================
// Command opcodes
`define OPC_WRITE_UNLOCK 8'h06
`define OPC_ARRAY_ERASE_A 8'h60
`define OPC_ARRAY_ERASE_B 8'hc7
`define OPC_PAGE_WRITE 8'h02
`define OPC_QUAD_PAGE_WRITE 8'h38
`define OPC_POWER_DOWN 8'hb9
`define OPC_POWER_DOWN_RELEASE 8'hab
`define OPC_SIGNATURE_READ 8'hab
`define OPC_SOFT_RESET 8'h99
`define OPC_OTP_ENTER 8'hb1
`define OPC_OTP_EXIT 8'hc1

// ====================================================================
// Geometry
`define ADDR_BYTES_SHORT 3'h3
`define ADDR_BYTES_LONG 3'h4
`define PAGE_LAST_IDX 8'hff
`define BLOCK_SHIFT 16
`define NUM_BLOCKS_DFLT 1024

// ====================================================================
// Timing
`define ARRAY_ERASE_TIME_US_DFLT 1000
`define PAGE_WRITE_TIME_NS 1000
`define PAGE_WRITE_CYC ((`PAGE_WRITE_TIME_NS * `REF_CLK_MHZ + 999) / 1000)
`define POWER_DOWN_ENTRY_DELAY_NS 1000
`define POWER_DOWN_ENTRY_CYC ((`POWER_DOWN_ENTRY_DELAY_NS * `REF_CLK_MHZ + 999) / 1000)

`endif

// file: inc/sfpes_pkg.sv
// ====================================================================
// Types shared by the sequencer and its bench
package sfpes_pkg;

  // Array operation kinds
  typedef enum logic [1:0] {
    SFPES_OP_NONE = 2'b00,
    SFPES_OP_PROG = 2'b01,
    SFPES_OP_ERASE_BLK = 2'b10,
    SFPES_OP_ERASE_ALL = 2'b11
  } sfpes_op_t;

  // One request to the array
  typedef struct packed {
    logic strobe;
    sfpes_op_t op;
    logic otp;
    logic [31:0] addr;
    logic [7:0] data;
  } sfpes_req_t;

  // Summary of one chip-select frame
  typedef struct packed {
    logic [7:0] opc;
    logic [31:0] addr;
    logic [15:0] nbytes;
    logic aligned;
    logic [2:0] abytes;
  } sfpes_frame_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_PROG_SCAN = 3'b010,
    ST_ERASE_SCAN = 3'b011,
    ST_BUSY_WAIT = 3'b100,
    ST_PD_WAIT = 3'b101
  } sfpes_state_t;

endpackage : sfpes_pkg

// file: hdl/sfpes_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfpes_defines.svh"

module sfpes_seq #(
  parameter int unsigned ARRAY_ERASE_TIME_US = `ARRAY_ERASE_TIME_US_DFLT,
  parameter int unsigned NUM_BLOCKS = `NUM_BLOCKS_DFLT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic [3:0] quad_io_lines,
  input wire logic qpi_mode,
  input wire logic addr4_mode,
  input wire logic quad_lines_enable,
  input wire logic protect_mode_select,
  input wire logic [3:0] block_protect_bits,
  input wire logic otp_lock_flag,
  input wire logic prot_query_locked,
  output logic [31:0] prot_query_addr,
  output logic prot_query_block,
  output sfpes_pkg::sfpes_req_t array_req,
  output logic write_unlock_latch,
  output logic op_in_progress_flag,
  output logic power_down,
  output logic otp_mode
);
  import sfpes_pkg::*;

  localparam int unsigned ERASE_CYC = ARRAY_ERASE_TIME_US * `REF_CLK_MHZ;
  localparam int unsigned PAGE_CYC = `PAGE_WRITE_CYC;
  localparam int unsigned PD_CYC = `POWER_DOWN_ENTRY_CYC;
  localparam logic [15:0] BLK_LAST = 16'(NUM_BLOCKS - 1);

  // ==================================================================
  // Link domain: frame capture on the serial clock

  logic armed_reg;
  logic [1:0] lqpi_reg;
  logic [1:0] laddr4_reg;
  logic [7:0] sh_reg;
  logic [7:0] opc_reg;
  logic [2:0] bitc_reg;
  logic [15:0] nbytes_reg;
  logic [31:0] laddr_reg;
  logic [7:0] pbuf [0:255];
  logic [255:0] pvalid_reg;
  logic [2:0] cur_bitc;
  logic [15:0] cur_bytes;
  logic [7:0] cur_opc;
  logic [31:0] cur_addr;
  logic [2:0] abytes;
  logic wide;
  logic [7:0] byte_next;
  logic [3:0] bit_sum;
  logic byte_done;
  logic in_data;
  logic [15:0] data_idx;
  logic [7:0] buf_pos;
  logic page_cmd;
  sfpes_frame_t link_frm;

  // Armed between frames; first serial edge of a frame clears it
  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // Mode levels brought onto the serial clock
  always_ff @(posedge link_sclk) begin
    lqpi_reg <= {lqpi_reg[0], qpi_mode};
    laddr4_reg <= {laddr4_reg[0], addr4_mode};
  end

  // Per-edge decode of the incoming bits
  always_comb begin
    cur_bitc = armed_reg ? 3'h0 : bitc_reg;
    cur_bytes = armed_reg ? 16'h0 : nbytes_reg;
    cur_opc = armed_reg ? 8'h0 : opc_reg;
    cur_addr = armed_reg ? 32'h0 : laddr_reg;
    abytes = laddr4_reg[1] ? `ADDR_BYTES_LONG : `ADDR_BYTES_SHORT;
    if (cur_bytes == 16'h0) begin
      wide = lqpi_reg[1];
    end else begin
      wide = lqpi_reg[1] || (cur_opc == `OPC_QUAD_PAGE_WRITE);
    end
    byte_next = wide ? {sh_reg[3:0], quad_io_lines} : {sh_reg[6:0], quad_io_lines[0]};
    bit_sum = {1'b0, cur_bitc} + (wide ? 4'h4 : 4'h1);
    byte_done = (bit_sum == 4'h8);
    in_data = cur_bytes > {13'h0, abytes};
    data_idx = cur_bytes - {13'h0, abytes} - 16'h1;
    buf_pos = cur_addr[7:0] + data_idx[7:0];
    page_cmd = (cur_opc == `OPC_PAGE_WRITE) || (cur_opc == `OPC_QUAD_PAGE_WRITE);
  end

  // Bit and byte counters
  always_ff @(posedge link_sclk) begin
    bitc_reg <= bit_sum[2:0];
    sh_reg <= byte_next;
    if (byte_done && (cur_bytes != 16'hffff)) begin
      nbytes_reg <= cur_bytes + 16'h1;
    end else begin
      nbytes_reg <= cur_bytes;
    end
  end

  // Opcode and address capture
  always_ff @(posedge link_sclk) begin
    opc_reg <= (byte_done && (cur_bytes == 16'h0)) ? byte_next : cur_opc;
    if (byte_done && (cur_bytes != 16'h0) && !in_data) begin
      laddr_reg <= {cur_addr[23:0], byte_next};
    end else begin
      laddr_reg <= cur_addr;
    end
  end

  always_ff @(posedge link_sclk) begin
    if (byte_done && in_data && page_cmd) begin
      pbuf[buf_pos] <= byte_next;
    end
  end

  always_ff @(posedge link_sclk) begin
    if (byte_done && in_data && page_cmd) begin
      pvalid_reg <= (armed_reg ? 256'h0 : pvalid_reg) | (256'h1 << buf_pos);
    end else begin
      pvalid_reg <= armed_reg ? 256'h0 : pvalid_reg;
    end
  end

  // Frame summary, static once chip select is high
  assign link_frm = '{opc: opc_reg, addr: laddr_reg, nbytes: nbytes_reg,
                      aligned: (bitc_reg == 3'h0), abytes: abytes};

  // ==================================================================
  // Reference domain: crossing of frame boundaries

  logic [2:0] cs_sync_reg;
  logic [1:0] arm_sync_reg;
  logic edges_seen_reg;
  logic cs_rise;

  // Chip select and armed level synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_sync_reg <= 3'h7;
      arm_sync_reg <= 2'h3;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      arm_sync_reg <= {arm_sync_reg[0], armed_reg};
    end
  end

  assign cs_rise = cs_sync_reg[1] && !cs_sync_reg[2];

  // Frame carried serial edges; a new edge wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      edges_seen_reg <= 1'b0;
    end else if (!cs_sync_reg[1] && !arm_sync_reg[1]) begin
      edges_seen_reg <= 1'b1;
    end else if (cs_rise) begin
      edges_seen_reg <= 1'b0;
    end
  end

  // ==================================================================
  // Reference domain: command decode and sequencing

  sfpes_state_t state_reg;
  sfpes_frame_t frm_reg;
  logic [15:0] idx_reg;
  logic [31:0] timer_reg;
  logic wel_reg;
  logic wip_reg;
  logic pd_reg;
  logic otp_reg;
  logic dec;
  logic exact;
  logic page_ok;
  logic is_erase;
  logic cmd_unlock;
  logic cmd_erase_go;
  logic cmd_prog_go;
  logic cmd_pd_go;
  logic cmd_wake;
  logic cmd_otp_in;
  logic cmd_otp_out;
  logic timer_done;

  // Frame latched when a frame ends while idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frm_reg <= '0;
    end else if ((state_reg == ST_IDLE) && cs_rise && edges_seen_reg) begin
      frm_reg <= link_frm;
    end
  end

  // Command decode
  always_comb begin
    dec = (state_reg == ST_DECODE);
    // opcode ends on a byte boundary
    exact = (frm_reg.nbytes == 16'h1) && frm_reg.aligned;
    // framing at a data byte edge
    page_ok = frm_reg.aligned && (frm_reg.nbytes > ({13'h0, frm_reg.abytes} + 16'h1));
    is_erase = (frm_reg.opc == `OPC_ARRAY_ERASE_A) || (frm_reg.opc == `OPC_ARRAY_ERASE_B);
    cmd_unlock = 1'b0;
    cmd_erase_go = 1'b0;
    cmd_prog_go = 1'b0;
    cmd_pd_go = 1'b0;
    cmd_wake = 1'b0;
    cmd_otp_in = 1'b0;
    cmd_otp_out = 1'b0;
    if (pd_reg) begin
      cmd_wake = dec && exact && ((frm_reg.opc == `OPC_POWER_DOWN_RELEASE) ||
                 (frm_reg.opc == `OPC_SIGNATURE_READ) || (frm_reg.opc == `OPC_SOFT_RESET));
    end else begin
      cmd_unlock = dec && exact && (frm_reg.opc == `OPC_WRITE_UNLOCK);
      cmd_erase_go = dec && exact && is_erase && wel_reg && !otp_reg &&
                     (protect_mode_select || (block_protect_bits == 4'h0));
      // latch gates page write; data present; protected page
      cmd_prog_go = dec && page_ok && wel_reg &&
                    ((frm_reg.opc == `OPC_PAGE_WRITE) ||
                     ((frm_reg.opc == `OPC_QUAD_PAGE_WRITE) && quad_lines_enable)) &&
                    (otp_reg ? !otp_lock_flag : !prot_query_locked);
      cmd_pd_go = dec && exact && (frm_reg.opc == `OPC_POWER_DOWN);
      cmd_otp_in = dec && exact && (frm_reg.opc == `OPC_OTP_ENTER);
      cmd_otp_out = dec && exact && (frm_reg.opc == `OPC_OTP_EXIT);
    end
  end

  assign timer_done = (timer_reg == 32'h0);

  // Sequencer state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cs_rise && edges_seen_reg) begin
            state_reg <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (cmd_prog_go) begin
            state_reg <= ST_PROG_SCAN;
          end else if (cmd_erase_go) begin
            state_reg <= protect_mode_select ? ST_ERASE_SCAN : ST_BUSY_WAIT;
          end else if (cmd_pd_go) begin
            state_reg <= ST_PD_WAIT;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_PROG_SCAN: begin
          if (idx_reg[7:0] == `PAGE_LAST_IDX) begin
            state_reg <= ST_BUSY_WAIT;
          end
        end
        ST_ERASE_SCAN: begin
          if (idx_reg == BLK_LAST) begin
            state_reg <= ST_BUSY_WAIT;
          end
        end
        ST_BUSY_WAIT, ST_PD_WAIT: begin
          if (timer_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Scan index over page bytes or blocks
  always_ff @(posedge ref_clk) begin
    if (!rst_n || dec) begin
      idx_reg <= 16'h0;
    end else if ((state_reg == ST_PROG_SCAN) || (state_reg == ST_ERASE_SCAN)) begin
      idx_reg <= idx_reg + 16'h1;
    end
  end

  // Self-timed delay counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer_reg <= 32'h0;
    end else if (cmd_erase_go && !protect_mode_select) begin
      timer_reg <= 32'(ERASE_CYC - 1);
    end else if ((state_reg == ST_ERASE_SCAN) && (idx_reg == BLK_LAST)) begin
      timer_reg <= 32'(ERASE_CYC - 1);
    end else if ((state_reg == ST_PROG_SCAN) && (idx_reg[7:0] == `PAGE_LAST_IDX)) begin
      timer_reg <= 32'(PAGE_CYC - 1);
    end else if (cmd_pd_go) begin
      timer_reg <= 32'(PD_CYC - 1);
    end else if (!timer_done) begin
      timer_reg <= timer_reg - 32'h1;
    end
  end

  // busy flag across the timed cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wip_reg <= 1'b0;
    end else if (cmd_prog_go || cmd_erase_go) begin
      wip_reg <= 1'b1;
    end else if ((state_reg == ST_BUSY_WAIT) && timer_done) begin
      wip_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else if (cmd_unlock) begin
      wel_reg <= 1'b1;
    end else if ((state_reg == ST_BUSY_WAIT) && timer_done) begin
      wel_reg <= 1'b0;
    end
  end

  // power-down left on wake or reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pd_reg <= 1'b0;
    end else if (cmd_wake) begin
      pd_reg <= 1'b0;
    end else if ((state_reg == ST_PD_WAIT) && timer_done) begin
      pd_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      otp_reg <= 1'b0;
    end else if (cmd_otp_in) begin
      otp_reg <= 1'b1;
    end else if (cmd_otp_out) begin
      otp_reg <= 1'b0;
    end
  end

  // Protection query: page during decode, block during scan
  always_comb begin
    prot_query_block = (state_reg == ST_ERASE_SCAN);
    if (prot_query_block) begin
      prot_query_addr = {idx_reg, 16'h0};
    end else begin
      prot_query_addr = frm_reg.addr;
    end
  end

  // Array request stream
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      array_req <= '0;
    end else if (cmd_erase_go && !protect_mode_select) begin
      array_req <= '{strobe: 1'b1, op: SFPES_OP_ERASE_ALL, otp: 1'b0, addr: 32'h0, data: 8'hff};
    end else if (state_reg == ST_ERASE_SCAN) begin
      array_req <= '{strobe: !prot_query_locked, op: SFPES_OP_ERASE_BLK, otp: 1'b0,
                     addr: {idx_reg, 16'h0}, data: 8'hff};
    end else if (state_reg == ST_PROG_SCAN) begin
      // array ANDs data in; lock checked at decode
      array_req <= '{strobe: pvalid_reg[idx_reg[7:0]], op: SFPES_OP_PROG, otp: otp_reg,
                     addr: {frm_reg.addr[31:8], idx_reg[7:0]}, data: pbuf[idx_reg[7:0]]};
    end else begin
      array_req <= '0;
    end
  end

  assign write_unlock_latch = wel_reg;
  assign op_in_progress_flag = wip_reg;
  assign power_down = pd_reg;
  assign otp_mode = otp_reg;

  // ==================================================================
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_busy_done;
    (state_reg == ST_BUSY_WAIT) && timer_done;
  endsequence

  sequence s_pd_go;
    dec && !pd_reg && exact && (frm_reg.opc == `OPC_POWER_DOWN);
  endsequence

  busy_end_clear_a: assert property (s_busy_done |=> !op_in_progress_flag && !write_unlock_latch)
    else $error("busy end did not clear flags");
  bp_refuse_a: assert property (dec && !pd_reg && exact && is_erase && !protect_mode_select &&
      (block_protect_bits != 4'h0) |=> !op_in_progress_flag [*4])
    else $error("erase ran under block protect");
  erase_all_a: assert property (cmd_erase_go && !protect_mode_select |=>
      array_req.strobe && (array_req.op == SFPES_OP_ERASE_ALL) ##1 !array_req.strobe)
    else $error("whole erase request wrong");
  unlock_gate_a: assert property (dec && !wel_reg && (is_erase ||
      (frm_reg.opc == `OPC_PAGE_WRITE)) |=> !op_in_progress_flag [*4])
    else $error("write ran without unlock");
  page_wrap_a: assert property (array_req.strobe && (array_req.op == SFPES_OP_PROG) |->
      (array_req.addr[31:8] == frm_reg.addr[31:8]))
    else $error("program left its page");
  otp_lock_a: assert property (array_req.strobe && array_req.otp |-> !otp_lock_flag)
    else $error("locked secured area written");
  pd_entry_a: assert property (s_pd_go |=> !power_down [*8] ##[1:300] power_down)
    else $error("power-down entry timing wrong");
  pd_ignore_a: assert property (power_down && dec && !cmd_wake |=>
      power_down && !op_in_progress_flag && (state_reg == ST_IDLE))
    else $error("command heeded in power-down");
  blk_skip_a: assert property ((state_reg == ST_ERASE_SCAN) && prot_query_locked |=>
      !array_req.strobe)
    else $error("protected block erased");
  quad_gate_a: assert property (dec && (frm_reg.opc == `OPC_QUAD_PAGE_WRITE) &&
      !quad_lines_enable |=> (state_reg == ST_IDLE) && !op_in_progress_flag)
    else $error("quad write without quad enable");
  frame_edge_a: assert property (dec && !frm_reg.aligned |=>
      (state_reg == ST_IDLE) && !op_in_progress_flag)
    else $error("misframed command executed");
  otp_target_a: assert property (array_req.strobe && (array_req.op == SFPES_OP_PROG) |->
      (array_req.otp == otp_mode))
    else $error("program target area wrong");

endmodule : sfpes_seq

`default_nettype wire

// file: tb/sfpes_host.sv
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// Host controller on the far side of the serial link
module sfpes_host (
  output logic link_sclk,
  output logic cs_n,
  output logic [3:0] quad_io_lines
);
  // Link idles with select high and the clock stopped
  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b1;
    quad_io_lines = 4'h0;
  end
  // One link edge: set the lines, then a 6 ns clock period
  task automatic tick(input logic [3:0] v);
    quad_io_lines = v;
    #3 link_sclk = 1'b1;
    #3 link_sclk = 1'b0;
  endtask : tick
  // frame of whole bytes, then xb stray edges to misalign it
  task automatic frame(input logic [7:0] b[$], input bit wo, input bit wb, input int xb);
    bit w;
    cs_n = 1'b0;
    #4;
    foreach (b[i]) begin
      w = (i == 0) ? wo : wb;
      if (w) begin
        tick(b[i][7:4]);
        tick(b[i][3:0]);
      end else begin
        // Unused lines carry the inverse so a design that reads them fails
        for (int k = 7; k >= 0; k--) tick({{3{~b[i][k]}}, b[i][k]});
      end
    end
    repeat (xb) tick(4'h1);
    #12 cs_n = 1'b1;
    // Released lines no longer show the last value
    quad_io_lines = ~quad_io_lines;
  endtask : frame
endmodule : sfpes_host
`default_nettype wire

// file: tb/serial_flash_program_erase_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_flash_program_erase_seq_tb;
  import sfpes_pkg::*;
  logic ref_clk, rst_n, qpi_mode, addr4_mode, quad_lines_enable, protect_mode_select;
  logic [3:0] block_protect_bits, quad_io_lines;
  logic otp_lock_flag, prot_query_locked, prot_query_block, link_sclk, cs_n;
  logic [31:0] prot_query_addr, rng;
  sfpes_req_t array_req;
  logic write_unlock_latch, op_in_progress_flag, power_down, otp_mode, lock_en;
  logic [15:0] lock_blk;
  logic [7:0] mem [longint];
  logic [7:0] exp_m [longint];
  logic [7:0] nq [$];
  int err_count, samples_checked, cycles;
  // ====================================================================
  // Design, host and protection lookup
  sfpes_seq #(.ARRAY_ERASE_TIME_US(2), .NUM_BLOCKS(4)) sfpes_seq_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_sclk(link_sclk), .cs_n(cs_n),
    .quad_io_lines(quad_io_lines), .qpi_mode(qpi_mode), .addr4_mode(addr4_mode),
    .quad_lines_enable(quad_lines_enable), .protect_mode_select(protect_mode_select),
    .block_protect_bits(block_protect_bits), .otp_lock_flag(otp_lock_flag),
    .prot_query_locked(prot_query_locked), .prot_query_addr(prot_query_addr),
    .prot_query_block(prot_query_block), .array_req(array_req),
    .write_unlock_latch(write_unlock_latch), .op_in_progress_flag(op_in_progress_flag),
    .power_down(power_down), .otp_mode(otp_mode));
  sfpes_host sfpes_host_inst (.link_sclk(link_sclk), .cs_n(cs_n), .quad_io_lines(quad_io_lines));
  // Lookup answers in the same cycle for the one locked block
  assign prot_query_locked = lock_en && (prot_query_addr[31:16] == lock_blk);
  // Clock generator
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      final_report();
    end
  end
  // ====================================================================
  // Array model fed by strobed requests
  function automatic longint key(input logic o, input logic [31:0] a);
    return longint'({o, a});
  endfunction : key
  function automatic logic [7:0] rm(input longint k);
    return mem.exists(k) ? mem[k] : 8'hff;
  endfunction : rm
  function automatic logic [7:0] re(input longint k);
    return exp_m.exists(k) ? exp_m[k] : 8'hff;
  endfunction : re
  always @(posedge ref_clk) begin
    if (array_req.strobe === 1'b1) begin
      case (array_req.op)
        SFPES_OP_PROG: mem[key(array_req.otp, array_req.addr)] =
          rm(key(array_req.otp, array_req.addr)) & array_req.data;
        SFPES_OP_ERASE_BLK: foreach (mem[k]) if (!k[32] && k[31:16] == array_req.addr[31:16])
          mem[k] = 8'hff;
        SFPES_OP_ERASE_ALL: foreach (mem[k]) if (!k[32]) mem[k] = 8'hff;
        default: ;
      endcase
    end
  end
  // ====================================================================
  // Shared tasks
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic cmd(input logic [7:0] opc, input int xb);
    sfpes_host_inst.frame({opc}, qpi_mode, qpi_mode, xb);
    repeat (10) @(negedge ref_clk);
  endtask : cmd
  // Busy must fall in bounded time, then latch and every expected location are compared
  task automatic finish_op(input bit go, input logic w0);
    repeat (8) @(negedge ref_clk);
    check(op_in_progress_flag, go);
    for (int i = 0; i < 3000 && op_in_progress_flag !== 1'b0; i++) @(negedge ref_clk);
    check(op_in_progress_flag, 1'b0);
    check(write_unlock_latch, go ? 1'b0 : w0);
    foreach (exp_m[k]) check(rm(k), exp_m[k]);
  endtask : finish_op
  // wrap and last 256 bytes win
  task automatic page(input logic [7:0] opc, input logic [31:0] a, input int n, input int xb,
                      input bit go);
    logic [7:0] b[$];
    logic [7:0] pb [256];
    bit pv [256];
    logic w0;
    w0 = write_unlock_latch;
    b = {opc};
    if (addr4_mode) b.push_back(a[31:24]);
    b.push_back(a[23:16]);
    b.push_back(a[15:8]);
    b.push_back(a[7:0]);
    for (int i = 0; i < n; i++) begin
      rng = xs(rng);
      b.push_back(rng[7:0]);
      pb[8'(a[7:0] + i)] = rng[7:0];
      pv[8'(a[7:0] + i)] = 1'b1;
    end
    if (go) foreach (pv[o]) if (pv[o]) exp_m[key(otp_mode, {a[31:8], 8'(o)})] =
      re(key(otp_mode, {a[31:8], 8'(o)})) & pb[o];
    sfpes_host_inst.frame(b, qpi_mode, qpi_mode || opc == 8'h38, xb);
    finish_op(go, w0);
  endtask : page
  // erase skips the locked block in per-sector mode
  task automatic erase(input int xb, input bit go);
    logic w0;
    w0 = write_unlock_latch;
    foreach (exp_m[k]) if (go && !k[32] && !(protect_mode_select && lock_en && k[31:16] == lock_blk))
      exp_m[k] = 8'hff;
    sfpes_host_inst.frame({8'hc7}, qpi_mode, qpi_mode, xb);
    finish_op(go, w0);
  endtask : erase
  // ====================================================================
  // Main sequence
  initial begin
    {rst_n, qpi_mode, addr4_mode, quad_lines_enable, protect_mode_select} = 5'h00;
    {block_protect_bits, otp_lock_flag, lock_en, lock_blk} = 22'h000000;
    rng = 32'd88;
    // Two stray edges flush the link-side mode synchronisers; select rise arms capture
    #1 sfpes_host_inst.frame(nq, 1'b0, 1'b0, 2);
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    page(8'h02, 32'h0000_1210, 4, 0, 0);
    cmd(8'h06, 0);
    check(write_unlock_latch, 1'b1);
    page(8'h02, 32'h0000_12f0, 20, 0, 1);
    cmd(8'h06, 0);
    addr4_mode = 1'b1;
    page(8'h02, 32'h0002_0300, 260, 0, 1);
    addr4_mode = 1'b0;
    cmd(8'h06, 0);
    page(8'h02, 32'h0002_0500, 3, 3, 0);
    lock_en = 1'b1;
    page(8'h02, 32'h0000_0400, 5, 0, 0);
    page(8'h38, 32'h0001_0400, 4, 0, 0);
    quad_lines_enable = 1'b1;
    page(8'h38, 32'h0000_0600, 4, 0, 0);
    lock_en = 1'b0;
    page(8'h38, 32'h0003_0040, 6, 0, 1);
    $display("page tests done");
    cmd(8'h06, 0);
    protect_mode_select = 1'b1;
    lock_en = 1'b1;
    erase(0, 1);
    {protect_mode_select, lock_en} = 2'b00;
    cmd(8'h06, 0);
    block_protect_bits = 4'h2;
    erase(0, 0);
    block_protect_bits = 4'h0;
    erase(3, 0);
    erase(0, 1);
    $display("erase tests done");
    cmd(8'hb9, 2);
    repeat (220) @(negedge ref_clk);
    check(power_down, 1'b0);
    cmd(8'hb9, 0);
    check(power_down, 1'b0);
    repeat (200) @(negedge ref_clk);
    check(power_down, 1'b1);
    cmd(8'h06, 0);
    check(write_unlock_latch, 1'b0);
    cmd(8'hab, 0);
    check(power_down, 1'b0);
    cmd(8'hb9, 0);
    repeat (210) @(negedge ref_clk);
    cmd(8'h99, 0);
    check(power_down, 1'b0);
    $display("power-down tests done");
    cmd(8'hb1, 0);
    check(otp_mode, 1'b1);
    cmd(8'h06, 0);
    page(8'h02, 32'h0000_0010, 4, 0, 1);
    cmd(8'h06, 0);
    otp_lock_flag = 1'b1;
    page(8'h02, 32'h0000_0020, 4, 0, 0);
    cmd(8'hc1, 0);
    check(otp_mode, 1'b0);
    $display("otp tests done");
    qpi_mode = 1'b1;
    sfpes_host_inst.frame({8'h00}, 1'b1, 1'b1, 0);
    repeat (10) @(negedge ref_clk);
    erase(0, 1);
    $display("four-line test done");
    final_report();
  end
endmodule : serial_flash_program_erase_seq_tb
`default_nettype wire
